/* File: logic/mlr_pkg.sv */
package mlr_pkg;
	localparam int CLK_HZ = 250_000_000;
	localparam int CYC_PER_MS = CLK_HZ / 1000;
	// Servo target: one feedback period per 8192 reference clocks
	localparam int OSC_DIV = 8192;
	localparam int FB_PER_MEAS = 2;
	localparam int TARGET_CYCLES = OSC_DIV * FB_PER_MEAS;
	// Lock window of 6.25 percent is one sixteenth of the target
	localparam int LOCK_SHIFT = 4;
	localparam int LOCK_WIN = TARGET_CYCLES >> LOCK_SHIFT;
	localparam int PER_W = 20;
	// Restraint interval: 0.33 s per uF, 10 uF assumed
	localparam int RESTRAINT_MS_PER_UF = 330;
	localparam int STOP_MS_PER_UF = 15;
	localparam int CAP_UF = 10;
	localparam int RESTRAINT_MS = RESTRAINT_MS_PER_UF * CAP_UF;
	localparam int RESTRAINT_CYCLES = RESTRAINT_MS * CYC_PER_MS;
	localparam int STOP_HOLD_CYCLES = STOP_MS_PER_UF * CAP_UF * CYC_PER_MS;
	localparam int RESTRAINT_W = 30;
	localparam int DUTY_W = 8;
	localparam logic [7:0] DUTY_INIT_RST = 8'h80;
	localparam int GAIN_SHIFT = 6;
	localparam int ADDR_W = 8;
	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_STATUS = 8'h04;
	localparam logic [7:0] ADDR_PERIOD = 8'h08;
	localparam logic [7:0] ADDR_DUTY = 8'h0c;
	localparam logic [7:0] ADDR_PHASE = 8'h10;
	localparam logic [7:0] ADDR_DUTY_INIT = 8'h14;
	localparam int CTRL_START_BIT = 0;
	localparam int ST_LOCK = 0;
	localparam int ST_TRIP = 1;
	localparam int ST_PSAVE = 2;
	localparam int ST_BRAKE = 3;
	localparam int ST_CLIM = 4;
	localparam int ST_DIR = 5;
	localparam int ST_PIN = 6;
	typedef enum logic [1:0] {
		MLR_STOP = 2'b00,
		MLR_RUN = 2'b01,
		MLR_BRAKE = 2'b10,
		MLR_TRIPPED = 2'b11
	} mlr_mode_e;
endpackage

/* File: logic/mlr_period_meter.sv */
`timescale 1ns/1ps
module mlr_period_meter #(
	parameter int PER_W = mlr_pkg::PER_W
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic fb_edge_i,
	output logic meas_valid_o,
	output logic [PER_W-1:0] period_o,
	output logic phase_valid_o,
	output logic [PER_W-1:0] phase_cnt_o
);
	localparam logic [PER_W-1:0] CNT_MAX = '1;
	logic [PER_W-1:0] cnt_reg, cnt_next, one_reg, one_next, per_reg, per_next, ph_reg, ph_next;
	logic half_reg, half_next, mv_reg, mv_next, pv_reg, pv_next;
	always_comb begin
		cnt_next = cnt_reg + 1'b1;
		one_next = one_reg + 1'b1;
		half_next = half_reg;
		per_next = per_reg;
		ph_next = ph_reg;
		mv_next = 1'b0;
		pv_next = 1'b0;
		if (!run_i) begin
			cnt_next = '0;
			one_next = '0;
			half_next = 1'b0;
		end else if (fb_edge_i) begin
			// Phase sample every feedback cycle, speed every second one
			pv_next = 1'b1; // [RULE16]
			// Edge cycle itself closes the interval, hence the extra count
			ph_next = one_reg + 1'b1;
			one_next = '0;
			half_next = !half_reg;
			if (half_reg) begin
				mv_next = 1'b1; // [RULE16]
				per_next = cnt_reg + 1'b1;
				cnt_next = '0;
			end
		end else if (cnt_reg == CNT_MAX) begin
			// Stalled rotor reports the longest period
			mv_next = 1'b1;
			per_next = CNT_MAX;
			cnt_next = '0;
			half_next = 1'b0;
		end
	end
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
			one_reg <= '0;
			ph_reg <= '0;
			per_reg <= '0;
			half_reg <= 1'b0;
			mv_reg <= 1'b0;
			pv_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			one_reg <= one_next;
			ph_reg <= ph_next;
			per_reg <= per_next;
			half_reg <= half_next;
			mv_reg <= mv_next;
			pv_reg <= pv_next;
		end
	end
	assign meas_valid_o = mv_reg;
	assign period_o = per_reg;
	assign phase_valid_o = pv_reg;
	assign phase_cnt_o = ph_reg;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	property p_two_edges;
		run_i && fb_edge_i && half_reg |=> meas_valid_o && phase_valid_o;
	endproperty
	a_two_edges: assert property (p_two_edges) else $error("no result on second edge"); // [RULE16]
endmodule

/* File: logic/mlr_restraint_timer.sv */
`timescale 1ns/1ps
module mlr_restraint_timer #(
	parameter int CNT_W = mlr_pkg::RESTRAINT_W,
	parameter int LIMIT = mlr_pkg::RESTRAINT_CYCLES
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic start_i,
	input wire logic unlocked_i,
	input wire logic cap_grounded_i,
	output logic tripped_o
);
	localparam logic [CNT_W-1:0] LAST = CNT_W'(LIMIT - 1);
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic trip_reg, trip_next;
	always_comb begin
		cnt_next = cnt_reg;
		trip_next = trip_reg;
		if (!start_i) begin
			cnt_next = '0;
			trip_next = 1'b0; // [RULE6]
		end else if (cap_grounded_i || !unlocked_i) begin
			cnt_next = '0; // [RULE17] [RULE7]
		end else if (!trip_reg) begin
			if (cnt_reg == LAST) begin
				trip_next = 1'b1; // [RULE4]
			end else begin
				cnt_next = cnt_reg + 1'b1;
			end
		end
	end
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg <= '0;
			trip_reg <= 1'b0;
		end else begin
			cnt_reg <= cnt_next;
			trip_reg <= trip_next;
		end
	end
	assign tripped_o = trip_reg;
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);
	property p_trip_holds;
		tripped_o && start_i |=> tripped_o;
	endproperty
	a_trip_holds: assert property (p_trip_holds) else $error("trip released while started"); // [RULE6]
	property p_restart;
		start_i && !unlocked_i |=> cnt_reg == '0;
	endproperty
	a_restart: assert property (p_restart) else $error("timer not cleared on lock"); // [RULE17]
	property p_expire;
		start_i && unlocked_i && !cap_grounded_i && cnt_reg == LAST |=> tripped_o;
	endproperty
	a_expire: assert property (p_expire) else $error("timer expired without trip"); // [RULE4]
endmodule

/* File: logic/mlr_motor_ctrl.sv */
// Function
// RULE1 - locked only within 6.25 percent of rated
// RULE2 - lock pin pulled low while locked
// RULE3 - out of window, duty corrected by deviation
// RULE4 - continuous unlock while started kills low side
// RULE5 - restraint interval about 0.33 s per uF
// RULE6 - trip holds until stop or power cycle
// RULE7 - grounded timing capacitor disables protection
// RULE8 - stop held 15 ms per uF before restart; not enforced here, a CTRL start write takes effect at once
// RULE9 - stop enters power save, regulator stays on
// RULE10 - current threshold cuts the on duty
// RULE11 - direction pin selects rotation, even running
// RULE12 - overcurrent after reversal gives short brake
// RULE13 - external clock via series resistor, output open
// RULE14 - direction low forward, high reverse
// RULE15 - servo rate is reference over 8192
// RULE16 - speed result every two feedback cycles
// RULE17 - relock restarts the restraint timer
//
// Implementation choices: the placing of the registers and the APB register port.
`timescale 1ns/1ps
module mlr_motor_ctrl #(
	parameter int RESTRAINT_CYCLES = mlr_pkg::RESTRAINT_CYCLES,
	parameter int DUTY_W = mlr_pkg::DUTY_W
) (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [mlr_pkg::ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic speed_feedback_pulse_i,
	input wire logic [2:0] hall_i,
	input wire logic dir_select_i,
	input wire logic cur_limit_i,
	input wire logic restraint_timer_cap_grounded_i,
	input wire logic lock_indicator_i,
	output logic lock_indicator_o,
	output logic lock_indicator_oe_n_o,
	output logic [2:0] high_on_o,
	output logic [2:0] low_on_o,
	output logic power_save_o,
	output logic internal_regulator_out_en_o
);
	localparam int PW = mlr_pkg::PER_W;
	localparam logic [PW:0] TARGET = (PW+1)'(mlr_pkg::TARGET_CYCLES); // [RULE15]
	localparam logic [PW:0] WIN = (PW+1)'(mlr_pkg::LOCK_WIN);
	localparam logic [DUTY_W-1:0] DUTY_MAX = '1;

	// Six-step commutation; reverse swaps upper and lower legs
	function automatic logic [5:0] commutate(input logic [2:0] h, input logic rev);
		logic [5:0] hl;
		hl = 6'h00;
		case (h)
			3'b001: hl = 6'h0a;
			3'b011: hl = 6'h0c;
			3'b010: hl = 6'h14;
			3'b110: hl = 6'h11;
			3'b100: hl = 6'h21;
			3'b101: hl = 6'h22;
			default: hl = 6'h00;
		endcase
		return rev ? {hl[2:0], hl[5:3]} : hl; // [RULE11]
	endfunction

	function automatic logic [PW:0] abs_dev(input logic [PW:0] d);
		return d[PW] ? (PW+1)'(-d) : d;
	endfunction

	function automatic logic [DUTY_W-1:0] sat_duty(input logic [DUTY_W-1:0] du,
			input logic [PW:0] d);
		logic [PW+1:0] s;
		logic [PW:0] step;
		s = '0;
		step = (PW+1)'($signed(d) >>> mlr_pkg::GAIN_SHIFT);
		if (step == '0) begin
			step = d[PW] ? '1 : (PW+1)'(1);
		end
		s = (PW+2)'(du) + {step[PW], step};
		if (s[PW+1]) begin
			return '0;
		end else if (s > (PW+2)'(DUTY_MAX)) begin
			return DUTY_MAX;
		end
		return s[DUTY_W-1:0];
	endfunction

	// Register file
	logic start_reg, start_next;
	logic [DUTY_W-1:0] dinit_reg, dinit_next;
	logic [31:0] rdata_reg, rdata_next;
	logic wr_en, mapped;

	// Speed loop and drive
	logic fb_prev_reg, fb_edge;
	logic meas_valid, phase_valid;
	logic [PW-1:0] period, phase_cnt;
	logic [PW:0] dev;
	logic locked_reg, locked_next;
	logic [PW-1:0] per_reg, per_next, phase_reg, phase_next;
	logic [DUTY_W-1:0] duty_reg, duty_next, pwm_cnt_reg, pwm_cnt_next;
	logic clim_reg, clim_next;
	logic dir_reg, dir_next, rev_pend_reg, rev_pend_next;
	logic tripped;
	mlr_pkg::mlr_mode_e mode;
	logic [2:0] high_reg, high_next, low_reg, low_next;
	logic psave_reg, psave_next, oe_n_reg, oe_n_next;
	logic [5:0] comm;

	assign mapped = paddr == mlr_pkg::ADDR_CTRL || paddr == mlr_pkg::ADDR_STATUS ||
		paddr == mlr_pkg::ADDR_PERIOD || paddr == mlr_pkg::ADDR_DUTY ||
		paddr == mlr_pkg::ADDR_PHASE || paddr == mlr_pkg::ADDR_DUTY_INIT;
	assign wr_en = psel && penable && pwrite;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;
	assign prdata = rdata_reg;

	always_comb begin
		start_next = start_reg;
		dinit_next = dinit_reg;
		rdata_next = rdata_reg;
		if (wr_en && paddr == mlr_pkg::ADDR_CTRL) begin
			start_next = pwdata[mlr_pkg::CTRL_START_BIT];
		end
		if (wr_en && paddr == mlr_pkg::ADDR_DUTY_INIT) begin
			dinit_next = pwdata[DUTY_W-1:0];
		end
		// Read data is fetched in the setup phase, ready in the access phase
		if (psel && !penable) begin
			rdata_next = '0;
			case (paddr)
				mlr_pkg::ADDR_CTRL: rdata_next[mlr_pkg::CTRL_START_BIT] = start_reg;
				mlr_pkg::ADDR_STATUS: begin
					rdata_next[mlr_pkg::ST_LOCK] = locked_reg;
					rdata_next[mlr_pkg::ST_TRIP] = tripped;
					rdata_next[mlr_pkg::ST_PSAVE] = psave_reg;
					rdata_next[mlr_pkg::ST_BRAKE] = mode == mlr_pkg::MLR_BRAKE;
					rdata_next[mlr_pkg::ST_CLIM] = clim_reg;
					rdata_next[mlr_pkg::ST_DIR] = dir_reg;
					rdata_next[mlr_pkg::ST_PIN] = lock_indicator_i;
				end
				mlr_pkg::ADDR_PERIOD: rdata_next[PW-1:0] = per_reg;
				mlr_pkg::ADDR_DUTY: rdata_next[DUTY_W-1:0] = duty_reg;
				mlr_pkg::ADDR_PHASE: rdata_next[PW-1:0] = phase_reg;
				mlr_pkg::ADDR_DUTY_INIT: rdata_next[DUTY_W-1:0] = dinit_reg;
				default: rdata_next = '0;
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			start_reg <= 1'b0;
			dinit_reg <= mlr_pkg::DUTY_INIT_RST;
			rdata_reg <= '0;
		end else begin
			start_reg <= start_next;
			dinit_reg <= dinit_next;
			rdata_reg <= rdata_next;
		end
	end

	assign fb_edge = speed_feedback_pulse_i && !fb_prev_reg;

	mlr_period_meter #(
		.PER_W(PW)
	) u_meter (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.run_i(start_reg),
		.fb_edge_i(fb_edge),
		.meas_valid_o(meas_valid),
		.period_o(period),
		.phase_valid_o(phase_valid),
		.phase_cnt_o(phase_cnt)
	);

	mlr_restraint_timer #(
		.CNT_W(mlr_pkg::RESTRAINT_W),
		.LIMIT(RESTRAINT_CYCLES) // [RULE5]
	) u_restraint (
		.ref_clk_i(ref_clk_i),
		.rst_i(rst_i),
		.start_i(start_reg),
		.unlocked_i(!locked_reg),
		.cap_grounded_i(restraint_timer_cap_grounded_i), // [RULE7]
		.tripped_o(tripped)
	);

	// Positive deviation means the rotor is slow
	assign dev = (PW+1)'(period) - TARGET;
	assign comm = commutate(hall_i, dir_reg);

	always_comb begin
		if (!start_reg) begin
			mode = mlr_pkg::MLR_STOP;
		end else if (tripped) begin
			mode = mlr_pkg::MLR_TRIPPED;
		end else if (rev_pend_reg && cur_limit_i) begin
			mode = mlr_pkg::MLR_BRAKE; // [RULE12]
		end else begin
			mode = mlr_pkg::MLR_RUN;
		end
	end

	always_comb begin
		locked_next = locked_reg;
		per_next = per_reg;
		phase_next = phase_reg;
		duty_next = duty_reg;
		if (!start_reg) begin
			locked_next = 1'b0;
			duty_next = dinit_reg;
		end else if (meas_valid) begin
			per_next = period;
			locked_next = abs_dev(dev) <= WIN; // [RULE1]
			if (abs_dev(dev) > WIN) begin
				duty_next = sat_duty(duty_reg, dev); // [RULE3]
			end
		end
		if (phase_valid) begin
			phase_next = phase_cnt;
		end
	end

	always_comb begin
		pwm_cnt_next = start_reg ? pwm_cnt_reg + 1'b1 : '0;
		clim_next = clim_reg;
		// Peak limit ends the on time for the rest of the PWM period
		if (pwm_cnt_next == '0) begin
			clim_next = 1'b0;
		end
		if (cur_limit_i && start_reg) begin
			clim_next = 1'b1; // [RULE10]
		end
		dir_next = dir_select_i; // [RULE14]
		rev_pend_next = rev_pend_reg;
		if (!start_reg || locked_reg) begin
			rev_pend_next = 1'b0;
		end
		if (start_reg && dir_select_i != dir_reg) begin
			rev_pend_next = 1'b1; // [RULE11]
		end
		psave_next = !start_reg; // [RULE9]
		oe_n_next = !locked_reg; // [RULE2]
		high_next = '0;
		low_next = '0;
		case (mode)
			mlr_pkg::MLR_RUN: begin
				high_next = comm[5:3];
				low_next = (pwm_cnt_reg < duty_reg && !clim_next) ? comm[2:0] : 3'b000;
			end
			mlr_pkg::MLR_BRAKE: begin
				high_next = 3'b111; // [RULE12]
				low_next = 3'b000;
			end
			mlr_pkg::MLR_TRIPPED: begin
				high_next = comm[5:3];
				low_next = 3'b000; // [RULE4]
			end
			default: begin
				high_next = 3'b000;
				low_next = 3'b000;
			end
		endcase
	end

	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			fb_prev_reg <= 1'b0;
			locked_reg <= 1'b0;
			per_reg <= '0;
			phase_reg <= '0;
			duty_reg <= mlr_pkg::DUTY_INIT_RST;
			pwm_cnt_reg <= '0;
			clim_reg <= 1'b0;
			dir_reg <= 1'b1;
			rev_pend_reg <= 1'b0;
			psave_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			high_reg <= '0;
			low_reg <= '0;
		end else begin
			fb_prev_reg <= speed_feedback_pulse_i;
			locked_reg <= locked_next;
			per_reg <= per_next;
			phase_reg <= phase_next;
			duty_reg <= duty_next;
			pwm_cnt_reg <= pwm_cnt_next;
			clim_reg <= clim_next;
			dir_reg <= dir_next;
			rev_pend_reg <= rev_pend_next;
			psave_reg <= psave_next;
			oe_n_reg <= oe_n_next;
			high_reg <= high_next;
			low_reg <= low_next;
		end
	end

	// Open collector: only ever pulls low
	assign lock_indicator_o = 1'b0;
	assign lock_indicator_oe_n_o = oe_n_reg;
	assign high_on_o = high_reg;
	assign low_on_o = low_reg;
	assign power_save_o = psave_reg;
	assign internal_regulator_out_en_o = 1'b1; // [RULE9]

	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (rst_i);

	property p_lock_in;
		start_reg && meas_valid && abs_dev(dev) <= WIN |=> locked_reg ##1 !lock_indicator_oe_n_o;
	endproperty
	a_lock_in: assert property (p_lock_in) else $error("in window but not locked"); // [RULE1]
	property p_lock_out;
		start_reg && meas_valid && abs_dev(dev) > WIN |=> !locked_reg ##1 lock_indicator_oe_n_o;
	endproperty
	a_lock_out: assert property (p_lock_out) else $error("out of window but locked"); // [RULE1]
	property p_pin;
		lock_indicator_oe_n_o == !$past(locked_reg);
	endproperty
	a_pin: assert property (p_pin) else $error("lock pin disagrees with lock state"); // [RULE2]
	property p_slow_up;
		start_reg && meas_valid && !dev[PW] && dev > WIN && duty_reg != DUTY_MAX
			|=> duty_reg > $past(duty_reg);
	endproperty
	a_slow_up: assert property (p_slow_up) else $error("duty not raised when slow"); // [RULE3]
	property p_trip_low;
		tripped |=> low_on_o == 3'b000;
	endproperty
	a_trip_low: assert property (p_trip_low) else $error("low side on after trip"); // [RULE4]
	property p_stop;
		!start_reg |=> power_save_o && high_on_o == 3'b000 && low_on_o == 3'b000;
	endproperty
	a_stop: assert property (p_stop) else $error("stop without power save"); // [RULE9]
	property p_clim;
		start_reg && cur_limit_i |=> low_on_o == 3'b000;
	endproperty
	a_clim: assert property (p_clim) else $error("low side on at current limit"); // [RULE10]
	property p_dir;
		!$past(rst_i) |-> dir_reg == $past(dir_select_i);
	endproperty
	a_dir: assert property (p_dir) else $error("direction not followed"); // [RULE14]
	property p_brake;
		start_reg && !tripped && rev_pend_reg && cur_limit_i
			|=> high_on_o == 3'b111 && low_on_o == 3'b000;
	endproperty
	a_brake: assert property (p_brake) else $error("no short brake after reversal"); // [RULE12]
endmodule

/* File: sim/mlr_motor_model.sv */
`timescale 1ns/1ps
module mlr_motor_model (
	input wire logic ref_clk_i,
	input wire logic rst_i,
	input wire logic run_i,
	input wire logic [19:0] period_i,
	output logic speed_feedback_pulse_o,
	output logic [2:0] hall_o
);
	logic [19:0] cnt_reg;
	logic [2:0] step_reg;
	// A stalled rotor gives no feedback edges and the pulse line stands low
	always_ff @(posedge ref_clk_i or posedge rst_i) begin
		if (rst_i) begin
			cnt_reg <= 20'h00000;
			step_reg <= 3'h0;
		end else if (!run_i) begin
			cnt_reg <= 20'h00000;
		end else if (cnt_reg >= period_i - 20'h00001) begin
			cnt_reg <= 20'h00000;
			step_reg <= (step_reg == 3'h5) ? 3'h0 : step_reg + 3'h1;
		end else begin
			cnt_reg <= cnt_reg + 20'h00001;
		end
	end
	assign speed_feedback_pulse_o = run_i && (cnt_reg < (period_i >> 1));
	always_comb begin
		case (step_reg)
			3'h0: hall_o = 3'h1;
			3'h1: hall_o = 3'h3;
			3'h2: hall_o = 3'h2;
			3'h3: hall_o = 3'h6;
			3'h4: hall_o = 3'h4;
			default: hall_o = 3'h5;
		endcase
	end
endmodule

/* File: sim/motor_lock_and_restraint_control_test.sv */
`timescale 1ns/1ps
`define CHK(a, e) check_val((a) === (e), 32'(a), 32'(e))
module motor_lock_and_restraint_control_test;
	localparam int RC = 2000;
	// Stop hold scaled down from 15 ms per uF for simulation
	localparam int STOP_HOLD = 150;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic fb;
	logic [2:0] hall;
	logic dir = 1'b0;
	logic cur_lim = 1'b0;
	logic cap_gnd = 1'b1;
	logic lock_pin;
	logic lock_o;
	logic lock_oe_n;
	logic [2:0] high_on;
	logic [2:0] low_on;
	logic psave;
	logic reg_en;
	logic run = 1'b0;
	logic [19:0] period = 20'h02200;
	logic [31:0] rd;
	logic [31:0] d1;
	int mismatches = 0;
	int n_checks = 0;
	// Reference clock fed straight in, no oscillator model
	always #2 ref_clk = ~ref_clk;
	// Open-collector lock pin with pull-up
	assign lock_pin = lock_oe_n ? 1'b1 : lock_o;
	mlr_motor_ctrl #(.RESTRAINT_CYCLES(RC)) mlr_motor_ctrl_i (
		.ref_clk_i(ref_clk), .rst_i(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.speed_feedback_pulse_i(fb), .hall_i(hall), .dir_select_i(dir), .cur_limit_i(cur_lim),
		.restraint_timer_cap_grounded_i(cap_gnd), .lock_indicator_i(lock_pin),
		.lock_indicator_o(lock_o), .lock_indicator_oe_n_o(lock_oe_n), .high_on_o(high_on),
		.low_on_o(low_on), .power_save_o(psave), .internal_regulator_out_en_o(reg_en));
	mlr_motor_model mlr_motor_model_i (.ref_clk_i(ref_clk), .rst_i(rst), .run_i(run),
		.period_i(period), .speed_feedback_pulse_o(fb), .hall_o(hall));
	task automatic check_val(input logic ok, input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (!ok) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic end_of_test();
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] wd,
		output logic [31:0] r, output logic err);
		int n;
		n = 0;
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		@(posedge ref_clk);
		while (pready !== 1'b1 && n < 16) begin
			n++;
			@(posedge ref_clk);
		end
		if (n == 16) begin
			`CHK(pready, 1'b1);
			end_of_test();
		end
		r = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask
	task automatic rd_reg(input logic [7:0] a, output logic [31:0] r);
		logic e;
		apb(1'b0, a, 32'h00000000, r, e);
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'b1, a, d, r, e);
	endtask
	task automatic wait_oe(input logic want, input int lim);
		int n;
		n = 0;
		while (lock_oe_n !== want && n < lim) begin
			n++;
			@(posedge ref_clk);
		end
		if (n == lim) begin
			`CHK(lock_oe_n, want);
			end_of_test();
		end
	endtask
	task automatic low_side(input int cyc, input logic want_on);
		logic [2:0] acc;
		acc = 3'h0;
		repeat (cyc) begin
			@(posedge ref_clk);
			acc = acc | low_on;
		end
		`CHK(acc != 3'h0, want_on);
	endtask
	task automatic t_reset();
		logic e;
		`CHK(psave, 1'b1);
		`CHK(reg_en, 1'b1);
		`CHK(lock_oe_n, 1'b1);
		rd_reg(mlr_pkg::ADDR_CTRL, rd);
		`CHK(rd, 32'h00000000);
		rd_reg(mlr_pkg::ADDR_DUTY_INIT, rd);
		`CHK(rd, 32'h00000080);
		apb(1'b0, 8'h18, 32'h00000000, rd, e);
		`CHK(e, 1'b1);
		`CHK(rd, 32'h00000000);
	endtask
	task automatic t_lock();
		wr_reg(mlr_pkg::ADDR_CTRL, 32'h00000001);
		run <= 1'b1;
		wait_oe(1'b0, 60000);
		repeat (17500) @(posedge ref_clk);
		rd_reg(mlr_pkg::ADDR_STATUS, rd);
		`CHK(rd[mlr_pkg::ST_LOCK], 1'b1);
		`CHK(rd[mlr_pkg::ST_PIN], 1'b0);
		`CHK(rd[mlr_pkg::ST_PSAVE], 1'b0);
		`CHK(psave, 1'b0);
		rd_reg(mlr_pkg::ADDR_PERIOD, rd);
		`CHK(rd, 32'h00004400);
		rd_reg(mlr_pkg::ADDR_PHASE, rd);
		`CHK(rd, 32'h00002200);
		// First result spans start to second edge: fast, so duty fell
		rd_reg(mlr_pkg::ADDR_DUTY, rd);
		`CHK(rd < 32'h00000080, 1'b1);
		low_side(300, 1'b1);
		cur_lim <= 1'b1;
		repeat (2) @(posedge ref_clk);
		low_side(300, 1'b0);
		rd_reg(mlr_pkg::ADDR_STATUS, rd);
		`CHK(rd[mlr_pkg::ST_CLIM], 1'b1);
		cur_lim <= 1'b0;
	endtask
	task automatic t_unlock();
		rd_reg(mlr_pkg::ADDR_DUTY, d1);
		period <= 20'h02201;
		wait_oe(1'b1, 60000);
		rd_reg(mlr_pkg::ADDR_STATUS, rd);
		`CHK(rd[mlr_pkg::ST_PIN], 1'b1);
		rd_reg(mlr_pkg::ADDR_DUTY, rd);
		`CHK(rd > d1, 1'b1);
	endtask
	task automatic t_brake();
		dir <= 1'b1;
		repeat (3) @(posedge ref_clk);
		cur_lim <= 1'b1;
		repeat (3) @(posedge ref_clk);
		`CHK(high_on, 3'h7);
		`CHK(low_on, 3'h0);
		rd_reg(mlr_pkg::ADDR_STATUS, rd);
		`CHK(rd[mlr_pkg::ST_BRAKE], 1'b1);
		`CHK(rd[mlr_pkg::ST_DIR], 1'b1);
		cur_lim <= 1'b0;
		dir <= 1'b0;
		repeat (3) @(posedge ref_clk);
		rd_reg(mlr_pkg::ADDR_STATUS, rd);
		`CHK(rd[mlr_pkg::ST_DIR], 1'b0);
	endtask
	task automatic t_stop();
		wr_reg(mlr_pkg::ADDR_CTRL, 32'h00000000);
		repeat (2) @(posedge ref_clk);
		`CHK(psave, 1'b1);
		`CHK(reg_en, 1'b1);
		rd_reg(mlr_pkg::ADDR_STATUS, rd);
		`CHK(rd[mlr_pkg::ST_PSAVE], 1'b1);
	endtask
	task automatic t_trip();
		run <= 1'b0;
		cap_gnd <= 1'b0;
		repeat (STOP_HOLD) @(posedge ref_clk);
		wr_reg(mlr_pkg::ADDR_CTRL, 32'h00000001);
		repeat (RC - 20) @(posedge ref_clk);
		rd_reg(mlr_pkg::ADDR_STATUS, rd);
		`CHK(rd[mlr_pkg::ST_TRIP], 1'b0);
		repeat (40) @(posedge ref_clk);
		rd_reg(mlr_pkg::ADDR_STATUS, rd);
		`CHK(rd[mlr_pkg::ST_TRIP], 1'b1);
		low_side(300, 1'b0);
		rd_reg(mlr_pkg::ADDR_STATUS, rd);
		`CHK(rd[mlr_pkg::ST_TRIP], 1'b1);
		wr_reg(mlr_pkg::ADDR_CTRL, 32'h00000000);
		rd_reg(mlr_pkg::ADDR_STATUS, rd);
		`CHK(rd[mlr_pkg::ST_TRIP], 1'b0);
	endtask
	task automatic t_grounded();
		cap_gnd <= 1'b1;
		repeat (STOP_HOLD) @(posedge ref_clk);
		wr_reg(mlr_pkg::ADDR_CTRL, 32'h00000001);
		repeat (RC * 2) @(posedge ref_clk);
		rd_reg(mlr_pkg::ADDR_STATUS, rd);
		`CHK(rd[mlr_pkg::ST_TRIP], 1'b0);
		wr_reg(mlr_pkg::ADDR_CTRL, 32'h00000000);
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		rst <= 1'b0;
		@(posedge ref_clk);
		t_reset();
		t_lock();
		t_unlock();
		t_brake();
		t_stop();
		t_trip();
		t_grounded();
		end_of_test();
	end
endmodule
